// file: src/conv_ctrl_defines.vh
// Register offsets, field positions, reset values and codes for the converter control block
// Assumes inclusion by bare name from the design files
`ifndef CONV_CTRL_DEFINES_VH
`define CONV_CTRL_DEFINES_VH

`define OFS_STATUS        8'h00
`define OFS_MASK          8'h04
`define OFS_MODE          8'h08
`define OFS_CUR_CTRL      8'h0c
`define OFS_VOLT_CTRL     8'h10
`define OFS_FILTER        8'h18
`define OFS_CONFIG        8'h1c
`define OFS_CUR_RESULT    8'h20
`define OFS_VOLT_RESULT   8'h24
`define OFS_THRESHOLD     8'h50
`define OFS_THR_LIMIT     8'h54
`define OFS_THR_COUNT     8'h58
`define OFS_ACCUM         8'h5c
`define OFS_REF_BUF       8'h64

`define RST_MODE          32'h00000003
`define RST_FILTER        32'h00000007
`define RST_THR_LIMIT     8'h01
`define RST_REF_BUF       1'b1

`define ST_CUR_RDY        0
`define ST_VOLT_RDY       1
`define ST_TEMP_RDY       2
`define ST_CMP            3
`define ST_CNT            4
`define ST_W              5

`define CFG_FAST          2
`define CFG_CMP_EN        3
`define CFG_CNT_EN        4
`define CFG_ACC_EN        5
`define CFG_GROUND_SWITCH_PIN        7

`define GAIN_HI           3
`define GAIN_LO           0
`define GAIN_MIN_SCALE    4'h4
`define SEL_HI            7
`define SEL_LO            4
`define SCALE_HI          11
`define SCALE_LO          10
`define DIAG_HI           13
`define DIAG_LO           12

`define VSEL_TEMP         4'h1

`define SETTLE_CONV       2'h2

`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// file: src/result_monitor.v
// Threshold comparator, event counter and result accumulator on the current channel
// Assumes result_valid is a one-cycle pulse with result stable in that cycle
`include "conv_ctrl_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module result_monitor (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        result_valid,
  input  wire [31:0] result,
  input  wire [31:0] threshold,
  input  wire [7:0]  count_limit,
  input  wire        cmp_en,
  input  wire        cnt_en,
  input  wire        acc_en,
  output reg         cmp_event,
  output reg         cnt_event,
  output reg  [7:0]  count_r,
  output reg  [31:0] accum_r
);

  wire [31:0] magnitude = result[31] ? (~result + 32'h00000001) : result;
  wire        over      = magnitude > threshold;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cmp_event <= 1'b0;
      cnt_event <= 1'b0;
      count_r   <= 8'h00;
      accum_r   <= 32'h00000000;
    end else begin
      cmp_event <= result_valid & cmp_en & over; // RL15
      cnt_event <= 1'b0;
      if (!cnt_en) begin
        count_r <= 8'h00;
      end else if (result_valid && over) begin
        if (count_r + 8'h01 >= count_limit) begin
          count_r   <= 8'h00;
          cnt_event <= 1'b1; // RL16
        end else begin
          count_r <= count_r + 8'h01;
        end
      end
      if (!acc_en) begin
        accum_r <= 32'h00000000;
      end else if (result_valid) begin
        accum_r <= accum_r + result; // RL17
      end
    end
  end

endmodule

`default_nettype wire

// file: src/conv_ctrl.v
// Converter control: fast temperature sequencing, selections, comparator, status, AXI4-Lite regs
// Assumes conv_done pulses once per conversion on aclk with both results stable in that cycle
//
// Contract
// (RL1) Normal channel switch: first settled result third
// (RL2) Fast request acts one conversion later
// (RL3) Software clears fast request after temperature result
// (RL4) Flags: V, then I+T, I, I, V
// (RL5) Software reads voltage before temperature flag
// (RL6) No fast request on first conversion
// (RL7) Software keeps decimation factor at least one
// (RL8) Software uses 1 ms conversion period
// (RL9) Config writes need fast bit cleared
// (RL10) Reference buffer off by default, external reference
// (RL11) Reference change leaves mode untouched
// (RL12) Gain scaling field bits 11:10, default both
// (RL13) Scaling decode; stage two needs gain 32+
// (RL14) Gain setting from bits 3:0
// (RL15) Interrupt when magnitude exceeds threshold
// (RL16) Interrupt when event count reaches limit
// (RL17) 32-bit accumulator of current results
// (RL18) Config bit 7 drives ground switch
// (RL19) Diagnostic input select choices per channel
// (RL20) Two diagnostic current sources per channel
// (RL21) All sources ORed to one interrupt
// (RL22) Current result read clears ready flags
// (RL23) Fast request held until software clears
`include "conv_ctrl_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module conv_ctrl (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        conv_done,
  input  wire [31:0] cur_data,
  input  wire [31:0] volt_data,
  output wire        temp_input_sel,
  output wire        fast_temp_mode,
  output wire        first_conv,
  output wire [31:0] converter_mode,
  output wire [31:0] filter_config,
  output wire [3:0]  amp_gain_select,
  output wire        scale_stage1_en,
  output wire        scale_stage2_en,
  output wire [3:0]  current_input_select,
  output wire [3:0]  voltage_input_select,
  output wire [1:0]  cur_diag_current_enable,
  output wire [1:0]  volt_diag_current_enable,
  output wire        ref_buffer_powerdown,
  output wire        ground_switch_pin,
  output wire        conv_irq
);

  localparam F_IDLE  = 2'h0;
  localparam F_TEMP  = 2'h1;
  localparam F_SET1  = 2'h2;
  localparam F_SET2  = 2'h3;

  reg  [31:0] mode_r;
  reg  [31:0] cur_ctrl_r;
  reg  [31:0] volt_ctrl_r;
  reg  [31:0] filter_r;
  reg  [7:0]  config_r;
  reg  [4:0]  mask_r;
  reg  [31:0] threshold_r;
  reg  [7:0]  limit_r;
  reg         ref_pd_r;
  reg  [4:0]  status_r;
  reg  [4:0]  status_nxt;
  reg  [31:0] cur_result_r;
  reg  [31:0] volt_result_r;
  reg  [1:0]  fstate_r;
  reg  [1:0]  settle_r;
  reg         first_r;
  reg         fast_used_r;
  reg         temp_sel_r;
  reg  [7:0]  aw_addr_r;
  reg         aw_have_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         w_have_r;

  wire        cmp_event;
  wire        cnt_event;
  wire [7:0]  thr_count;
  wire [31:0] accum;

  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire       wr_fire = aw_have_r & w_have_r;
  wire       rd_fire = s_axi_arvalid & ~s_axi_rvalid;
  wire [7:0] waddr   = aw_addr_r;

  wire wr_mode   = wr_fire && waddr == `OFS_MODE;
  wire wr_cur    = wr_fire && waddr == `OFS_CUR_CTRL;
  wire wr_volt   = wr_fire && waddr == `OFS_VOLT_CTRL;
  wire wr_filter = wr_fire && waddr == `OFS_FILTER;
  wire rd_cur    = rd_fire && s_axi_araddr == `OFS_CUR_RESULT;
  wire rd_volt   = rd_fire && s_axi_araddr == `OFS_VOLT_RESULT;
  wire rd_status = rd_fire && s_axi_araddr == `OFS_STATUS;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r    <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_have_r     <= 1'b0;
      w_data_r     <= 32'h00000000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (waddr)
          `OFS_MASK, `OFS_MODE, `OFS_CUR_CTRL, `OFS_VOLT_CTRL, `OFS_FILTER,
          `OFS_CONFIG, `OFS_THRESHOLD, `OFS_THR_LIMIT, `OFS_REF_BUF:
            s_axi_bresp <= `RESP_OKAY;
          default:
            s_axi_bresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_r      <= `RST_MODE;
      cur_ctrl_r  <= 32'h00000000;
      volt_ctrl_r <= 32'h00000000;
      filter_r    <= `RST_FILTER;
      config_r    <= 8'h00;
      mask_r      <= 5'h00;
      threshold_r <= 32'h00000000;
      limit_r     <= `RST_THR_LIMIT;
      ref_pd_r    <= `RST_REF_BUF; // RL10
    end else if (wr_fire) begin
      case (waddr)
        `OFS_MODE:      mode_r      <= merge(mode_r, w_data_r, w_strb_r);
        `OFS_CUR_CTRL:  cur_ctrl_r  <= merge(cur_ctrl_r, w_data_r, w_strb_r);
        `OFS_VOLT_CTRL: volt_ctrl_r <= merge(volt_ctrl_r, w_data_r, w_strb_r);
        `OFS_FILTER:    filter_r    <= merge(filter_r, w_data_r, w_strb_r);
        `OFS_CONFIG:    if (w_strb_r[0]) config_r <= w_data_r[7:0]; // RL23
        `OFS_MASK:      if (w_strb_r[0]) mask_r <= w_data_r[4:0];
        `OFS_THRESHOLD: threshold_r <= merge(threshold_r, w_data_r, w_strb_r);
        `OFS_THR_LIMIT: if (w_strb_r[0]) limit_r <= w_data_r[7:0];
        `OFS_REF_BUF:   if (w_strb_r[0]) ref_pd_r <= w_data_r[0]; // RL11
        default:        mode_r      <= mode_r;
      endcase
    end
  end

  // Voltage/temperature channel sequencing
  wire fast_req  = config_r[`CFG_FAST];
  wire want_temp = volt_ctrl_r[`SEL_HI:`SEL_LO] == `VSEL_TEMP;
  wire settled   = settle_r == 2'h0;
  wire fast_go   = fstate_r == F_IDLE && fast_req && !first_r && !fast_used_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      fstate_r    <= F_IDLE;
      settle_r    <= 2'h0;
      first_r     <= 1'b1;
      fast_used_r <= 1'b0;
      temp_sel_r  <= 1'b0;
    end else begin
      if (wr_mode || wr_cur || wr_filter) begin
        first_r <= 1'b1; // RL9
      end else if (conv_done) begin
        first_r <= 1'b0; // RL6
      end
      if (!fast_req) begin
        fast_used_r <= 1'b0;
      end
      if (conv_done) begin
        case (fstate_r)
          F_IDLE: begin
            if (fast_go) begin
              fstate_r    <= F_TEMP; // RL2
              fast_used_r <= 1'b1;
              temp_sel_r  <= 1'b1;
            end else if (want_temp != temp_sel_r) begin
              temp_sel_r <= want_temp;
              settle_r   <= `SETTLE_CONV; // RL1
            end else if (!settled) begin
              settle_r <= settle_r - 2'h1;
            end
          end
          F_TEMP: begin
            fstate_r   <= F_SET1;
            temp_sel_r <= want_temp;
          end
          F_SET1:  fstate_r <= F_SET2;
          F_SET2:  fstate_r <= F_IDLE;
          default: fstate_r <= F_IDLE;
        endcase
      end else if (fstate_r == F_IDLE && want_temp != temp_sel_r) begin
        temp_sel_r <= want_temp;
        settle_r   <= `SETTLE_CONV; // RL1
      end
    end
  end

  // Which flags this conversion raises
  wire flag_v = fstate_r == F_IDLE && settled && !temp_sel_r
              && want_temp == temp_sel_r; // RL4
  wire flag_t = fstate_r == F_TEMP
              || (fstate_r == F_IDLE && settled && temp_sel_r && want_temp == temp_sel_r);

  always @(posedge aclk) begin
    if (!aresetn) begin
      cur_result_r  <= 32'h00000000;
      volt_result_r <= 32'h00000000;
    end else if (conv_done) begin
      cur_result_r <= cur_data;
      if (flag_v || flag_t) begin
        volt_result_r <= volt_data;
      end
    end
  end

  // Status: set wins over every clear
  always @* begin
    status_nxt = status_r;
    if (rd_cur) begin
      status_nxt[`ST_TEMP_RDY:`ST_CUR_RDY] = 3'b000; // RL22
    end
    if (rd_volt || wr_volt) begin
      status_nxt[`ST_VOLT_RDY] = 1'b0;
    end
    if (rd_status) begin
      status_nxt[`ST_CNT:`ST_CMP] = 2'b00;
    end
    if (wr_cur) begin
      status_nxt = 5'h00;
    end
    if (conv_done) begin
      status_nxt[`ST_CUR_RDY] = 1'b1;
      if (flag_v) begin
        status_nxt[`ST_VOLT_RDY] = 1'b1;
      end
      if (flag_t) begin
        status_nxt[`ST_TEMP_RDY] = 1'b1;
      end
    end
    if (cmp_event) begin
      status_nxt[`ST_CMP] = 1'b1;
    end
    if (cnt_event) begin
      status_nxt[`ST_CNT] = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= 5'h00;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign conv_irq = |(status_r & mask_r); // RL21

  result_monitor u_monitor (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .result_valid (conv_done),
    .result       (cur_data),
    .threshold    (threshold_r),
    .count_limit  (limit_r),
    .cmp_en       (config_r[`CFG_CMP_EN]),
    .cnt_en       (config_r[`CFG_CNT_EN]),
    .acc_en       (config_r[`CFG_ACC_EN]),
    .cmp_event    (cmp_event),
    .cnt_event    (cnt_event),
    .count_r      (thr_count),
    .accum_r      (accum)
  );

  // Read path
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      case (s_axi_araddr[7:2])
        `OFS_STATUS      >> 2: s_axi_rdata <= {27'h0000000, status_r};
        `OFS_MASK        >> 2: s_axi_rdata <= {27'h0000000, mask_r};
        `OFS_MODE        >> 2: s_axi_rdata <= mode_r;
        `OFS_CUR_CTRL    >> 2: s_axi_rdata <= cur_ctrl_r;
        `OFS_VOLT_CTRL   >> 2: s_axi_rdata <= volt_ctrl_r;
        `OFS_FILTER      >> 2: s_axi_rdata <= filter_r;
        `OFS_CONFIG      >> 2: s_axi_rdata <= {24'h000000, config_r};
        `OFS_CUR_RESULT  >> 2: s_axi_rdata <= cur_result_r;
        `OFS_VOLT_RESULT >> 2: s_axi_rdata <= volt_result_r;
        `OFS_THRESHOLD   >> 2: s_axi_rdata <= threshold_r;
        `OFS_THR_LIMIT   >> 2: s_axi_rdata <= {24'h000000, limit_r};
        `OFS_THR_COUNT   >> 2: s_axi_rdata <= {24'h000000, thr_count};
        `OFS_ACCUM       >> 2: s_axi_rdata <= accum; // RL17
        `OFS_REF_BUF     >> 2: s_axi_rdata <= {31'h00000000, ref_pd_r};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Converter-facing controls
  wire [1:0] scale_code = cur_ctrl_r[`SCALE_HI:`SCALE_LO]; // RL12
  assign amp_gain_select  = cur_ctrl_r[`GAIN_HI:`GAIN_LO]; // RL14
  assign scale_stage1_en  = ~scale_code[0]; // RL13
  assign scale_stage2_en  = ~scale_code[1] & (amp_gain_select >= `GAIN_MIN_SCALE); // RL13
  assign current_input_select = cur_ctrl_r[`SEL_HI:`SEL_LO]; // RL19
  assign voltage_input_select = volt_ctrl_r[`SEL_HI:`SEL_LO]; // RL19
  assign cur_diag_current_enable  = cur_ctrl_r[`DIAG_HI:`DIAG_LO]; // RL20
  assign volt_diag_current_enable = volt_ctrl_r[`DIAG_HI:`DIAG_LO]; // RL20
  assign ref_buffer_powerdown = ref_pd_r; // RL10
  assign ground_switch_pin    = config_r[`CFG_GROUND_SWITCH_PIN]; // RL18
  assign temp_input_sel  = temp_sel_r;
  assign fast_temp_mode  = fstate_r == F_TEMP;
  assign first_conv      = first_r;
  assign converter_mode  = mode_r;
  assign filter_config   = filter_r;

endmodule

`default_nettype wire

// file: dv/conv_ctrl_sva.sv
// Concurrent checks on the converter control block ports
// Assumes binding onto conv_ctrl, one clock domain, synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module conv_ctrl_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        conv_done,
  input wire logic        temp_input_sel,
  input wire logic        fast_temp_mode,
  input wire logic        first_conv,
  input wire logic [31:0] converter_mode,
  input wire logic [3:0]  amp_gain_select,
  input wire logic        scale_stage2_en,
  input wire logic        ref_buffer_powerdown,
  input wire logic        ground_switch_pin,
  input wire logic        conv_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ref_default: assert property ($rose(aresetn) |-> ref_buffer_powerdown)
    else $error("reference buffer not powered down after reset");
  a_gnd_quiet: assert property ($rose(aresetn) |-> !ground_switch_pin && !conv_irq)
    else $error("ground switch or interrupt active after reset");
  a_stage2_gain: assert property (scale_stage2_en |-> amp_gain_select >= 4'h4)
    else $error("stage two scaling with gain below 32");
  a_fast_entry: assert property ($rose(fast_temp_mode) |->
    temp_input_sel && $past(conv_done) && !$past(first_conv))
    else $error("fast mode entered off a conversion");
  a_fast_leave: assert property (fast_temp_mode && conv_done |=>
    !fast_temp_mode && !temp_input_sel)
    else $error("fast mode lasted beyond one conversion");
  a_mode_steady: assert property ($changed(converter_mode) |-> $rose(s_axi_bvalid))
    else $error("mode changed without a register write");
  a_ref_mode: assert property ($changed(ref_buffer_powerdown) |-> $stable(converter_mode))
    else $error("reference change disturbed the mode");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
endmodule
bind conv_ctrl conv_ctrl_sva sva_i (.*);
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the converter control block
// Assumes conv_ctrl and its checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
  end \
end
module testbench;
  logic        aclk = '0;
  logic        aresetn = '0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0, conv_done = '0;
  logic [31:0] s_axi_wdata = '0, cur_data = '0, volt_data = '0, rdv;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  rsp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp, cur_diag_current_enable, volt_diag_current_enable;
  wire [31:0]  s_axi_rdata, converter_mode, filter_config;
  wire         temp_input_sel, fast_temp_mode, first_conv, scale_stage1_en, scale_stage2_en;
  wire [3:0]   amp_gain_select, current_input_select, voltage_input_select;
  wire         ref_buffer_powerdown, ground_switch_pin, conv_irq;
  int          failures = 0, n_checks = 0;
  logic [31:0] cc [4] = '{32'h00000803, 32'h00000403, 32'h00000404, 32'h00000c09};
  logic [1:0]  ex [4] = '{2'b01, 2'b00, 2'b10, 2'b00};
  logic [1:0]  st [3] = '{2'h1, 2'h1, 2'h3};

  conv_ctrl DUT (.*);

  always #50 aclk = ~aclk;

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) failures++;
    `CHK("bresp", e, s_axi_bresp)
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) failures++;
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, rdv);
    `CHK("read data", e, rdv)
  endtask

  // One conversion pulse, then time for monitor flags to land
  task automatic conv(input logic [31:0] c, input logic [31:0] v);
    cur_data  <= c;
    volt_data <= v;
    conv_done <= 1'b1;
    @(posedge aclk);
    conv_done <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic t_reset;
    `CHK("ref_pd", 1'b1, ref_buffer_powerdown)
    `CHK("irq", 1'b0, conv_irq)
    `CHK("first", 1'b1, first_conv)
    rchk(8'h08, 32'h00000003);
    rchk(8'h18, 32'h00000007);
    rchk(8'h64, 32'h00000001);
    rchk(8'h54, 32'h00000001);
    rchk(8'h0c, 32'h00000000);
    rchk(8'h40, 32'h00000000);
    `CHK("rresp", 2'b10, rsp)
    wr(8'h7c, 32'h00000001, 2'b10);
  endtask

  task automatic t_fields;
    wr(8'h0c, 32'h00003054, 2'b00);
    `CHK("gain", 4'h4, amp_gain_select)
    `CHK("cur_sel", 4'h5, current_input_select)
    `CHK("cur_diag", 2'h3, cur_diag_current_enable)
    `CHK("scale", 2'b11, {scale_stage2_en, scale_stage1_en})
    foreach (cc[i]) begin
      wr(8'h0c, cc[i], 2'b00);
      `CHK("scale", ex[i], {scale_stage2_en, scale_stage1_en})
    end
    wr(8'h10, 32'h00002030, 2'b00);
    `CHK("volt_sel", 4'h3, voltage_input_select)
    `CHK("volt_diag", 2'h2, volt_diag_current_enable)
    wr(8'h1c, 32'h00000080, 2'b00);
    `CHK("ground_switch_pin", 1'b1, ground_switch_pin)
    wr(8'h64, 32'h00000000, 2'b00);
    `CHK("ref_pd", 1'b0, ref_buffer_powerdown)
    `CHK("mode", 32'h00000003, converter_mode)
    wr(8'h1c, 32'h00000000, 2'b00);
    `CHK("ground_switch_pin", 1'b0, ground_switch_pin)
  endtask

  task automatic t_fast;
    wr(8'h04, 32'h0000001f, 2'b00);
    wr(8'h08, 32'h00000001, 2'b00);
    `CHK("mode", 32'h00000001, converter_mode)
    wr(8'h18, 32'h00000007, 2'b00);
    `CHK("filter", 32'h00000007, filter_config)
    `CHK("first", 1'b1, first_conv)
    conv(32'h00000010, 32'h00000020);
    `CHK("first", 1'b0, first_conv)
    rd(8'h20, rdv);
    wr(8'h1c, 32'h00000004, 2'b00);
    `CHK("fast", 1'b0, fast_temp_mode)
    conv(32'h00000011, 32'h00000021);
    `CHK("fast_sel", 2'b11, {fast_temp_mode, temp_input_sel})
    `CHK("irq", 1'b1, conv_irq)
    rchk(8'h00, 32'h00000003);
    rchk(8'h24, 32'h00000021);
    rd(8'h20, rdv);
    rchk(8'h00, 32'h00000000);
    `CHK("irq", 1'b0, conv_irq)
    conv(32'h00000012, 32'h0000005a);
    `CHK("fast_sel", 2'b00, {fast_temp_mode, temp_input_sel})
    rchk(8'h00, 32'h00000005);
    rchk(8'h24, 32'h0000005a);
    rchk(8'h1c, 32'h00000004);
    wr(8'h1c, 32'h00000000, 2'b00);
    foreach (st[i]) begin
      rd(8'h20, rdv);
      conv(32'h00000013, 32'h00000023);
      rchk(8'h00, {30'h0, st[i]});
    end
  endtask

  task automatic t_settle;
    wr(8'h10, 32'h00000010, 2'b00);
    for (int i = 0; i < 3; i++) begin
      rd(8'h20, rdv);
      conv(32'h00000014, 32'h00000024);
      rd(8'h00, rdv);
      `CHK("settled", (i == 2), (rdv[2:1] != 2'b00))
    end
  endtask

  task automatic t_cmp;
    wr(8'h50, 32'h00000064, 2'b00);
    wr(8'h54, 32'h00000002, 2'b00);
    wr(8'h04, 32'h00000018, 2'b00);
    wr(8'h1c, 32'h00000038, 2'b00);
    rd(8'h00, rdv);
    conv(32'hffffff6a, 32'h00000000);
    `CHK("irq", 1'b1, conv_irq)
    rchk(8'h58, 32'h00000001);
    rd(8'h00, rdv);
    `CHK("cmp_flags", 2'b01, rdv[4:3])
    `CHK("irq", 1'b0, conv_irq)
    conv(32'h00000064, 32'h00000000);
    rd(8'h00, rdv);
    `CHK("cmp_flags", 2'b00, rdv[4:3])
    conv(32'h000000c8, 32'h00000000);
    `CHK("irq", 1'b1, conv_irq)
    rd(8'h00, rdv);
    `CHK("cmp_flags", 2'b11, rdv[4:3])
    rchk(8'h58, 32'h00000000);
    rchk(8'h5c, 32'h00000096);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_fields();
    t_fast();
    t_settle();
    t_cmp();
    tally_and_finish();
  end

  // About 240 cycles expected; cut off well beyond that
  initial begin
    #2000000;
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
